//--- hdl/bsup_cmp_if.sv
// synchronised comparator levels passed from the synchroniser to the core
`timescale 1ns/1ps
`default_nettype none

interface bsup_cmp_if;
  logic vcc_ok;
  logic en_ok;
  logic ss_low;
  logic ss_done;
  logic overcurrent_latch;
  logic temp;
  logic win;
  logic overvoltage_trip;
  logic seq_hi;
  logic sync;

  modport src (output vcc_ok, en_ok, ss_low, ss_done, overcurrent_latch, temp, win, overvoltage_trip, seq_hi, sync);
  modport dst (input vcc_ok, en_ok, ss_low, ss_done, overcurrent_latch, temp, win, overvoltage_trip, seq_hi, sync);
endinterface

`default_nettype wire

//--- hdl/bsup_pkg.sv
// types shared by the buck supervisor modules
package bsup_pkg;

  // ==========================================================================
  // supervisor states
  typedef enum logic [2:0] {
    S_OFF,
    S_RUN,
    S_SSHOLD,
    S_HICCUP,
    S_THERM,
    S_OVT,
    S_OVL
  } bsup_state_t;

endpackage

//--- hdl/bsup_regs.svh
// register offsets, reset values and timing counts of the buck supervisor
`ifndef BSUP_REGS_SVH
`define BSUP_REGS_SVH

// ==========================================================================
// register map
`define BSUP_CTRL_OFS 8'h00
`define BSUP_DUTY_OFS 8'h04
`define BSUP_PERIOD_OFS 8'h08
`define BSUP_STATUS_OFS 8'h0C
`define BSUP_SYNC_EN_BIT 0
`define BSUP_CTRL_RST 32'h0000_0001
`define BSUP_DUTY_RST 8'h08
`define BSUP_PERIOD_RST 8'h2A

// ==========================================================================
// timing
`define BSUP_CLK_NS 40
`define BSUP_BLANK_NS 160
`define BSUP_BLANK_CYC ((`BSUP_BLANK_NS + `BSUP_CLK_NS - 1) / `BSUP_CLK_NS)
`define BSUP_OFF_NS 200
`define BSUP_OFF_CYC ((`BSUP_OFF_NS + `BSUP_CLK_NS - 1) / `BSUP_CLK_NS)
`define BSUP_MIN_ON_NS 50
`define BSUP_MIN_ON_CYC ((`BSUP_MIN_ON_NS + `BSUP_CLK_NS - 1) / `BSUP_CLK_NS)
`define BSUP_HICCUP_CYC 4096
`define BSUP_PG_DELAY_CYC 256
`define BSUP_PB_PULSES 8

`endif

//--- hdl/bsup_sync.sv
// two-stage synchronisers for all analog comparator and sync inputs
`timescale 1ns/1ps
`default_nettype none

module bsup_sync (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic vcc_ok_in,
  input wire logic en_ok_in,
  input wire logic ss_low_in,
  input wire logic ss_done_in,
  input wire logic ocp_cmp_in,
  input wire logic temp_trip_in,
  input wire logic vsns_win_in,
  input wire logic ovp_cmp_in,
  input wire logic seq_hi_in,
  input wire logic sync_in,
  bsup_cmp_if.src cmp
);
  logic [9:0] raw;
  logic [9:0] s1;
  logic [9:0] s2;

  assign raw = {sync_in, seq_hi_in, ovp_cmp_in, vsns_win_in, temp_trip_in,
                ocp_cmp_in, ss_done_in, ss_low_in, en_ok_in, vcc_ok_in};

  // ==========================================================================
  // synchroniser chain, first stage read only by the second
  for (genvar i = 0; i < 10; i++) begin : g_sync
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        s1[i] <= 1'b0;
        s2[i] <= 1'b0;
      end else begin
        s1[i] <= raw[i];
        s2[i] <= s1[i];
      end
    end
  end

  assign cmp.vcc_ok = s2[0];
  assign cmp.en_ok = s2[1];
  assign cmp.ss_low = s2[2];
  assign cmp.ss_done = s2[3];
  assign cmp.overcurrent_latch = s2[4];
  assign cmp.temp = s2[5];
  assign cmp.win = s2[6];
  assign cmp.overvoltage_trip = s2[7];
  assign cmp.seq_hi = s2[8];
  assign cmp.sync = s2[9];
endmodule // bsup_sync

`default_nettype wire

//--- hdl/bsup_top.sv
// buck regulator fault and power-good supervisor with apb registers
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "bsup_regs.svh"

module bsup_top
  import bsup_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic vcc_ok_in,
  input wire logic en_ok_in,
  input wire logic ss_low_in,
  input wire logic ss_done_in,
  input wire logic ocp_cmp_in,
  input wire logic temp_trip_in,
  input wire logic vsns_win_in,
  input wire logic ovp_cmp_in,
  input wire logic seq_hi_in,
  input wire logic sync_in,
  output logic hs_gate_out,
  output logic ls_gate_out,
  output logic drv_hiz_out,
  output logic ss_discharge_out,
  output logic ref_sel_out,
  output logic pgood_out,
  output logic pgood_oe_out,
  output logic overcurrent_latch_out
);
  localparam int BLANK_CYC = `BSUP_BLANK_CYC;
  localparam int OFF_CYC = `BSUP_OFF_CYC;
  localparam int MIN_ON_CYC = `BSUP_MIN_ON_CYC;
  localparam int HICCUP_CYC = `BSUP_HICCUP_CYC;
  localparam int PG_CYC = `BSUP_PG_DELAY_CYC;
  localparam int PB_PULSES = `BSUP_PB_PULSES;

  bsup_cmp_if c ();

  bsup_sync u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .vcc_ok_in(vcc_ok_in),
    .en_ok_in(en_ok_in),
    .ss_low_in(ss_low_in),
    .ss_done_in(ss_done_in),
    .ocp_cmp_in(ocp_cmp_in),
    .temp_trip_in(temp_trip_in),
    .vsns_win_in(vsns_win_in),
    .ovp_cmp_in(ovp_cmp_in),
    .seq_hi_in(seq_hi_in),
    .sync_in(sync_in),
    .cmp(c)
  );

  bsup_state_t state;
  logic [7:0] period;
  logic [7:0] duty;
  logic sync_en;
  logic [7:0] phase_cnt;
  logic sync_d;
  logic pb_armed;
  logic [1:0] ls_step;
  logic [2:0] pb_cnt;
  logic [3:0] blank_cnt;
  logic [12:0] hic_cnt;
  logic [8:0] pg_cnt;
  logic ocl;
  logic por;
  logic running;
  logic tick;
  logic sync_rise;
  logic prebias_done;
  logic [7:0] max_on;
  logic [7:0] on_eff;
  logic [7:0] off_len;
  logic [7:0] ls_pos;
  logic [2:0] ls_mult;
  logic [10:0] ls_prod;
  logic skip;
  logic cyc_live;
  logic [7:0] duty_cur;
  logic hs_cmd;
  logic ls_cmd;
  logic oc_detect;
  logic hic_done;
  logic pg_cond;
  logic apb_wr;

  // ==========================================================================
  // power-on-ready and switching oscillator
  assign por = c.vcc_ok & c.en_ok;
  assign running = (state == S_RUN);
  assign prebias_done = (ls_step == 2'd3);
  assign sync_rise = c.sync & ~sync_d;
  // once the pre-bias ramp is done and sync_en is set, an early sync edge truncates the cycle; free-run period otherwise
  assign tick = (phase_cnt >= period - 8'd1) |
                (sync_rise & sync_en & prebias_done);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync_d <= 1'b0;
      phase_cnt <= 8'h00;
    end else begin
      sync_d <= c.sync;
      phase_cnt <= tick ? 8'h00 : phase_cnt + 8'd1;
    end
  end

  // ==========================================================================
  // pulse widths
  // a period shorter than the off time plus minimum on-time only skips
  assign max_on = (period > 8'(OFF_CYC)) ? period - 8'(OFF_CYC) : 8'h00;
  assign on_eff = (duty_cur > max_on) ? max_on : duty_cur;
  assign skip = (on_eff < 8'(MIN_ON_CYC));
  assign off_len = period - on_eff;
  assign ls_pos = phase_cnt - on_eff;
  assign ls_mult = {1'b0, ls_step} + 3'd1;
  assign ls_prod = 11'(off_len) * 11'(ls_mult);
  assign hs_cmd = running & cyc_live & ~skip & (phase_cnt < on_eff);
  assign ls_cmd = running & pb_armed & (phase_cnt >= on_eff) &
                  (ls_pos < ls_prod[9:2]);

  // ==========================================================================
  // pre-bias low-side ramp
  always_ff @(posedge clk_in) begin
    if (rst_in || !running) begin
      pb_armed <= 1'b0;
      ls_step <= 2'd0;
      pb_cnt <= 3'd0;
      cyc_live <= 1'b0;
      duty_cur <= `BSUP_DUTY_RST;
    end else begin
      cyc_live <= cyc_live | tick; // no partial first pulse on entry
      duty_cur <= tick ? duty : duty_cur; // a duty write never cuts a pulse
      if (hs_cmd) begin
        pb_armed <= 1'b1;
      end
      if (tick && pb_armed && !prebias_done) begin
        if (pb_cnt == 3'(PB_PULSES - 1)) begin
          pb_cnt <= 3'd0;
          ls_step <= ls_step + 2'd1;
        end else begin
          pb_cnt <= pb_cnt + 3'd1;
        end
      end
    end
  end

  // ==========================================================================
  // current sense blanking and overcurrent
  always_ff @(posedge clk_in) begin
    if (rst_in || !ls_gate_out) begin
      blank_cnt <= 4'd0;
    end else if (blank_cnt < 4'(BLANK_CYC)) begin
      blank_cnt <= blank_cnt + 4'd1;
    end
  end

  assign oc_detect = running & ls_gate_out & (blank_cnt >= 4'(BLANK_CYC)) & c.overcurrent_latch;
  assign hic_done = (state == S_HICCUP) & tick & (hic_cnt == 13'(HICCUP_CYC - 1));

  always_ff @(posedge clk_in) begin
    if (rst_in || !por) begin
      ocl <= 1'b0;
    end else if (oc_detect) begin
      ocl <= 1'b1;
    end else if (hic_done) begin
      ocl <= 1'b0;
    end
  end

  // counts switching cycles, not clocks, so the hold tracks the frequency
  always_ff @(posedge clk_in) begin
    if (rst_in || state != S_HICCUP) begin
      hic_cnt <= 13'd0;
    end else if (tick) begin
      hic_cnt <= hic_cnt + 13'd1;
    end
  end

  // ==========================================================================
  // supervisor state machine
  always_ff @(posedge clk_in) begin
    if (rst_in || !por) begin
      state <= S_OFF;
    end else if (c.overvoltage_trip && state != S_OVT && state != S_OVL) begin
      state <= S_OVT;
    end else if (c.temp && state != S_OVT && state != S_OVL) begin
      state <= S_THERM;
    end else begin
      unique case (state)
        S_OFF: state <= S_RUN;
        S_RUN: begin
          if (c.ss_low) begin
            state <= S_SSHOLD;
          end else if (oc_detect) begin
            state <= S_HICCUP;
          end
        end
        S_SSHOLD: if (!c.ss_low) state <= S_RUN;
        S_HICCUP: if (hic_done) state <= S_RUN;
        S_THERM: state <= S_RUN;
        S_OVT: if (!c.overvoltage_trip) state <= S_OVL;
        S_OVL: state <= S_OVL;
      endcase
    end
  end

  // ==========================================================================
  // gate drivers, soft-start and reference selection
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hs_gate_out <= 1'b0;
      ls_gate_out <= 1'b0;
      drv_hiz_out <= 1'b1;
      ss_discharge_out <= 1'b1;
      ref_sel_out <= 1'b0;
    end else begin
      hs_gate_out <= hs_cmd;
      ls_gate_out <= ls_cmd | (state == S_OVT);
      drv_hiz_out <= (state == S_OFF);
      ss_discharge_out <= (state == S_OFF) | (state == S_HICCUP) |
                          (state == S_THERM);
      ref_sel_out <= c.seq_hi;
    end
  end

  // ==========================================================================
  // power good
  assign pg_cond = running & c.ss_done & c.win;

  always_ff @(posedge clk_in) begin
    if (rst_in || !pg_cond) begin
      pg_cnt <= 9'd0;
    end else if (tick && pg_cnt < 9'(PG_CYC)) begin
      pg_cnt <= pg_cnt + 9'd1;
    end
  end

  // pin only ever pulls low; the high level comes from the board pull-up
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pgood_out <= 1'b0;
      pgood_oe_out <= 1'b1;
      overcurrent_latch_out <= 1'b0;
    end else begin
      pgood_out <= 1'b0;
      pgood_oe_out <= ~(pg_cond & (pg_cnt == 9'(PG_CYC)));
      overcurrent_latch_out <= ocl;
    end
  end

  // ==========================================================================
  // apb slave, one wait-free access phase
  assign apb_wr = psel_in & penable_in & pwrite_in & pready_out;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync_en <= 1'(`BSUP_CTRL_RST);
      duty <= `BSUP_DUTY_RST;
      period <= `BSUP_PERIOD_RST;
    end else if (apb_wr) begin
      unique case (paddr_in)
        `BSUP_CTRL_OFS: sync_en <= pwdata_in[`BSUP_SYNC_EN_BIT];
        `BSUP_DUTY_OFS: duty <= pwdata_in[7:0];
        `BSUP_PERIOD_OFS: period <= pwdata_in[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in & ~penable_in;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      if (psel_in && !penable_in) begin
        unique case (paddr_in)
          `BSUP_CTRL_OFS: prdata_out <= {31'h0, sync_en};
          `BSUP_DUTY_OFS: prdata_out <= {24'h0, duty};
          `BSUP_PERIOD_OFS: prdata_out <= {24'h0, period};
          `BSUP_STATUS_OFS: prdata_out <= {24'h0, state, ~pgood_oe_out,
                                           ocl, prebias_done, ref_sel_out, skip};
          default: pslverr_out <= 1'b1;
        endcase
      end
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_enable_tristate: assert property (!por |-> ##2 drv_hiz_out)
    else $error("drivers not tristated after power-on-ready loss");
  a_ss_stop: assert property (state == S_SSHOLD |=> !hs_gate_out && !ls_gate_out)
    else $error("switching during soft-start hold");
  a_oc_hiccup: assert property (oc_detect && por && !c.overvoltage_trip && !c.temp && !c.ss_low
    |=> ocl && state == S_HICCUP)
    else $error("overcurrent not latched into hiccup");
  a_hiccup_disch: assert property (state == S_HICCUP |=> ss_discharge_out ##1 ss_discharge_out
    or (state != S_HICCUP))
    else $error("soft-start not discharged in hiccup");
  a_sense_blank: assert property ($rose(ls_gate_out) |-> !oc_detect[*4])
    else $error("current sensed inside blanking");
  a_thermal_off: assert property (state == S_THERM
    |=> !hs_gate_out && !ls_gate_out && ss_discharge_out)
    else $error("switches active in thermal shutdown");
  a_therm_restart: assert property (state == S_THERM && !c.temp && !c.overvoltage_trip && por
    |=> state == S_RUN)
    else $error("no restart after temperature clears");
  a_pg_window: assert property (!c.win |=> pgood_oe_out)
    else $error("power good released outside window");
  a_pg_delay: assert property ($fell(pgood_oe_out) |-> $past(pg_cnt) == 9'(PG_CYC))
    else $error("power good released before delay");
  a_ov_drive: assert property (state == S_OVT |=> !hs_gate_out && ls_gate_out)
    else $error("wrong drive during over-voltage");
  a_ov_latch: assert property (state == S_OVL && por |=> state == S_OVL ##1 !hs_gate_out)
    else $error("over-voltage latch released");
  a_min_on: assert property ($rose(hs_gate_out) && running |=> hs_gate_out)
    else $error("high-side pulse below minimum");

  c_hiccup: cover property (hic_done);
  c_pgood: cover property ($fell(pgood_oe_out));
  c_ov_latch: cover property (state == S_OVT ##1 state == S_OVL);
  c_sync_lock: cover property (sync_rise && sync_en && prebias_done);
endmodule // bsup_top

`default_nettype wire

//--- verif/bsup_bench.sv
// self-checking bench for the buck supervisor
`timescale 1ns/1ps
`default_nettype none
`include "bsup_regs.svh"

module buck_fault_and_power_good_supervisor_bench
  import bsup_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic ss_low = 1'b0, ss_done = 1'b0, overcurrent_latch = 1'b0, temp = 1'b0;
  logic win = 1'b0, overvoltage_trip = 1'b0, seq_hi = 1'b0;
  logic pwr_on = 1'b1, en_on = 1'b0, sync_on = 1'b0;
  logic vcc_ok, en_ok, sync, pg_line;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, hs_gate_out, ls_gate_out, drv_hiz_out;
  logic ss_discharge_out, ref_sel_out, pgood_out, pgood_oe_out, ocl_out;
  int n_fail = 0;
  int check_count = 0;
  logic [31:0] rd;
  logic err;
  int n;

  always #20 clk_in = ~clk_in;

  bsup_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .vcc_ok_in(vcc_ok),
    .en_ok_in(en_ok), .ss_low_in(ss_low), .ss_done_in(ss_done), .ocp_cmp_in(overcurrent_latch),
    .temp_trip_in(temp), .vsns_win_in(win), .ovp_cmp_in(overvoltage_trip), .seq_hi_in(seq_hi),
    .sync_in(sync), .hs_gate_out(hs_gate_out), .ls_gate_out(ls_gate_out),
    .drv_hiz_out(drv_hiz_out), .ss_discharge_out(ss_discharge_out),
    .ref_sel_out(ref_sel_out), .pgood_out(pgood_out), .pgood_oe_out(pgood_oe_out),
    .overcurrent_latch_out(ocl_out));

  bsup_board_model board_u (.clk_in(clk_in), .pwr_on_in(pwr_on), .en_on_in(en_on),
    .sync_on_in(sync_on), .pgood_in(pgood_out), .pgood_oe_in(pgood_oe_out),
    .vcc_ok_out(vcc_ok), .en_ok_out(en_ok), .sync_out(sync), .pgood_line_out(pg_line));

  // ==========================================================================
  // helpers
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // one apb transfer; the request stands until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk_in);
      if (pready_out === 1'b1) break;
    end
    rd = prdata_out;
    err = pslverr_out;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      n_fail++;
      end_of_test();
    end
  endtask

  task automatic chk_state(input bsup_state_t s, input string what);
    apb(1'b0, `BSUP_STATUS_OFS, 32'h0);
    chk32({29'h0, rd[7:5]}, {29'h0, s}, what);
  endtask

  task automatic count_hs(input int cyc, input logic low_side = 1'b0);
    n = 0;
    repeat (cyc) begin
      @(posedge clk_in);
      if ((low_side ? ls_gate_out : hs_gate_out) === 1'b1) n++;
    end
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_regs();
    apb(1'b0, `BSUP_CTRL_OFS, 32'h0);
    chk32(rd, `BSUP_CTRL_RST, "ctrl reset");
    apb(1'b0, `BSUP_DUTY_OFS, 32'h0);
    chk32(rd, {24'h0, `BSUP_DUTY_RST}, "duty reset");
    apb(1'b0, `BSUP_PERIOD_OFS, 32'h0);
    chk32(rd, {24'h0, `BSUP_PERIOD_RST}, "period reset");
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    chk1(err, 1'b1, "unmapped error");
    apb(1'b1, `BSUP_PERIOD_OFS, 32'h0000_0008);
    apb(1'b0, `BSUP_PERIOD_OFS, 32'h0);
    chk32(rd, 32'h0000_0008, "period write");
    $display("t_regs done");
  endtask

  task automatic t_enable();
    chk1(drv_hiz_out, 1'b1, "hiz while disabled");
    chk_state(S_OFF, "off without enable");
    @(posedge clk_in) en_on <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk_state(S_RUN, "run on por");
    chk1(drv_hiz_out, 1'b0, "drivers live");
    @(posedge clk_in) en_on <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk1(drv_hiz_out, 1'b1, "hiz on enable low");
    @(posedge clk_in) en_on <= 1'b1;
    repeat (400) @(posedge clk_in);
    $display("t_enable done");
  endtask

  task automatic t_duty();
    apb(1'b1, `BSUP_DUTY_OFS, 32'h0000_00FF);
    repeat (16) @(posedge clk_in);
    count_hs(32);
    chk32(n, 4 * (8 - `BSUP_OFF_CYC), "off interval");
    apb(1'b1, `BSUP_DUTY_OFS, 32'h0000_0001);
    repeat (16) @(posedge clk_in);
    count_hs(32);
    chk32(n, 0, "short pulse skipped");
    apb(1'b1, `BSUP_DUTY_OFS, 32'h0000_0002);
    repeat (16) @(posedge clk_in);
    count_hs(32);
    chk32(n, 8, "minimum pulse kept");
    $display("t_duty done");
  endtask

  task automatic t_sync();
    @(posedge clk_in) sync_on <= 1'b1;
    repeat (24) @(posedge clk_in);
    count_hs(48);
    chk32(n, 16, "locked to sync");
    apb(1'b1, `BSUP_CTRL_OFS, 32'h0);
    repeat (24) @(posedge clk_in);
    count_hs(48);
    chk32(n, 12, "sync disabled");
    apb(1'b1, `BSUP_CTRL_OFS, `BSUP_CTRL_RST);
    @(posedge clk_in) sync_on <= 1'b0;
    repeat (24) @(posedge clk_in);
    count_hs(48);
    chk32(n, 12, "free running");
    $display("t_sync done");
  endtask

  task automatic t_pgood();
    @(posedge clk_in) win <= 1'b1;
    repeat (2400) @(posedge clk_in);
    chk1(pg_line, 1'b0, "held before ss delay");
    @(posedge clk_in) ss_done <= 1'b1;
    for (n = 0; n < 4000 && pgood_oe_out !== 1'b0; n++) @(posedge clk_in);
    if (n == 4000) begin
      n_fail++;
      end_of_test();
    end
    chk1(n >= 256 * 8 - 8 && n <= 256 * 8 + 16, 1'b1, "pgood delay");
    chk1(pg_line, 1'b1, "pgood released");
    @(posedge clk_in) win <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk1(pg_line, 1'b0, "pgood out of window");
    $display("t_pgood done");
  endtask

  task automatic t_ss();
    @(posedge clk_in) ss_low <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk_state(S_SSHOLD, "soft-start hold");
    count_hs(32);
    chk32(n, 0, "no switching");
    @(posedge clk_in) ss_low <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk_state(S_RUN, "resume");
    repeat (400) @(posedge clk_in);
    $display("t_ss done");
  endtask

  task automatic t_ocp();
    @(posedge clk_in) overcurrent_latch <= 1'b1;
    repeat (40) @(posedge clk_in);
    overcurrent_latch <= 1'b0;
    chk1(ocl_out, 1'b1, "latch set");
    chk_state(S_HICCUP, "hiccup");
    chk1(ss_discharge_out, 1'b1, "ss shorted");
    repeat (4096 * 8 - 200) @(posedge clk_in);
    chk_state(S_HICCUP, "still counting");
    repeat (400) @(posedge clk_in);
    chk_state(S_RUN, "recovered");
    chk1(ocl_out, 1'b0, "latch cleared");
    repeat (400) @(posedge clk_in);
    @(posedge clk_in) overcurrent_latch <= 1'b1;
    repeat (40) @(posedge clk_in);
    overcurrent_latch <= 1'b0;
    chk_state(S_HICCUP, "hiccup again");
    $display("t_ocp done");
  endtask

  task automatic t_therm();
    @(posedge clk_in) temp <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk_state(S_THERM, "thermal stop");
    chk1(ss_discharge_out, 1'b1, "thermal discharge");
    chk1(hs_gate_out | ls_gate_out, 1'b0, "thermal gates off");
    @(posedge clk_in) temp <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk_state(S_RUN, "thermal restart");
    repeat (400) @(posedge clk_in);
    $display("t_therm done");
  endtask

  task automatic t_ovp();
    @(posedge clk_in) overvoltage_trip <= 1'b1;
    repeat (8) @(posedge clk_in);
    chk1(ls_gate_out & ~hs_gate_out, 1'b1, "ov crowbar");
    chk_state(S_OVT, "ov trip");
    @(posedge clk_in) overvoltage_trip <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk_state(S_OVL, "ov latched");
    chk1(hs_gate_out | ls_gate_out, 1'b0, "ov gates off");
    @(posedge clk_in) en_on <= 1'b0;
    repeat (6) @(posedge clk_in);
    en_on <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk_state(S_RUN, "por recycle");
    count_hs(32, 1'b1);
    chk1(n >= 1 && n <= 4, 1'b1, "low-side starts narrow");
    repeat (400) @(posedge clk_in);
    count_hs(32, 1'b1);
    chk32(n, 4 * (8 - 2), "low-side full width");
    $display("t_ovp done");
  endtask

  task automatic t_track();
    repeat (6) @(posedge clk_in);
    chk1(ref_sel_out, 1'b0, "follow tracking");
    @(posedge clk_in) seq_hi <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk1(ref_sel_out, 1'b1, "internal reference");
    $display("t_track done");
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    t_regs();
    t_enable();
    t_duty();
    t_sync();
    t_pgood();
    t_ss();
    t_ocp();
    t_therm();
    t_ovp();
    t_track();
    end_of_test();
  end
endmodule // buck_fault_and_power_good_supervisor_bench

`default_nettype wire

//--- verif/bsup_board_model.sv
// board side model: supplies, external sync clock and power-good pull-up
`timescale 1ns/1ps
`default_nettype none

module bsup_board_model (
  input wire logic clk_in,
  input wire logic pwr_on_in,
  input wire logic en_on_in,
  input wire logic sync_on_in,
  input wire logic pgood_in,
  input wire logic pgood_oe_in,
  output logic vcc_ok_out,
  output logic en_ok_out,
  output logic sync_out,
  output logic pgood_line_out
);
  logic [2:0] sync_cnt = 3'h0;

  // ==========================================================================
  // supplies
  assign vcc_ok_out = pwr_on_in;
  assign en_ok_out = en_on_in;

  // ==========================================================================
  // sync clock: six clocks a period, three high (120 ns) to clear the width limit
  always @(posedge clk_in) begin
    sync_cnt <= (sync_cnt == 3'h5) ? 3'h0 : sync_cnt + 3'h1;
  end
  assign sync_out = sync_on_in && (sync_cnt < 3'h3);

  // ==========================================================================
  // pull-up: the line reads high whenever the device lets go
  assign pgood_line_out = pgood_oe_in ? pgood_in : 1'b1;
endmodule // bsup_board_model

`default_nettype wire
